// [src/lfs_scrambler.sv]
// Self-synchronizing x^58 + x^39 + 1 scrambler / descrambler, serial or 32-bit
//
// Operation
// [RULE1] Both directions use x^58 + x^39 + 1, tapping state delays 58 and 39.
// [RULE2] The word form is a 58-bit state register plus a 32-wide XOR tree.
// [RULE3] The XOR tree reads data, state 58..27 and state 39..8 before update.
// [RULE4] Output bit i is state bit i+27 XOR state bit i+8 XOR input bit i.
// [RULE5] The state is always fed scrambled data: output word when scrambling.
// [RULE6] A word step moves state 26..1 to 58..33 and scrambled data to 32..1.
// [RULE7] Serial output is the single input bit XOR state bits 58 and 39.
// [RULE8] A serial scramble step shifts up one and inserts the output bit.
// [RULE9] Reinitialize loads the fixed seed 0x00294387 / 0x98327338.
// [RULE10] Bypass passes data unchanged and holds the state.
// [RULE11] Reinitialize beats bypass; output still follows bypass meanwhile.
// [RULE12] A serial descramble step inserts the received bit, not the output.
// [RULE13] State updates on a clock edge only when data is presented; reinit and srst load SEED without data.
// [RULE14] A synchronous block reset loads the same seed as reinitialize.
`timescale 1ns/1ps
`default_nettype none
module lfs_scrambler
  import lfs_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              srst,
  // Mode (static during traffic)
  input  wire logic              descramble,
  input  wire logic              serial_mode,
  // Per-step controls from the framing side
  input  wire logic              reinit,
  input  wire logic              bypass,
  // Input stream
  input  wire logic              in_valid,
  input  wire logic [WORD_W-1:0] in_data,
  output var  logic              in_ready,
  // Output stream
  output var  logic              out_valid,
  output var  logic [WORD_W-1:0] out_data,
  input  wire logic              out_ready,
  // State visibility
  output var  logic [STATE_W-1:0] state_r
);
  // ----------------------------------------------------------------
  // XOR tree
  // ----------------------------------------------------------------
  logic              step;
  logic [WORD_W-1:0] tree_out;
  logic [WORD_W-1:0] word_out;
  logic              ser_in;
  logic              ser_out;
  logic              ser_fb;
  logic [WORD_W-1:0] par_fb;

  assign step   = in_valid & in_ready;
  assign ser_in = in_data[0];

  // [RULE3] tree inputs
  // [RULE4] bitwise taps
  assign tree_out = in_data ^ state_r[STATE_W-1 -: WORD_W]
                            ^ state_r[TAP_LO-1 -: WORD_W];

  // [RULE1] serial taps
  // [RULE7] single bit
  assign ser_out = ser_in ^ state_r[TAP_HI-1] ^ state_r[TAP_LO-1];

  // [RULE10] bypass passthrough
  always_comb begin
    if (bypass) begin
      word_out = serial_mode ? {{(WORD_W-1){1'b0}}, ser_in} : in_data;
    end else if (serial_mode) begin
      word_out = {{(WORD_W-1){1'b0}}, ser_out};
    end else begin
      word_out = tree_out;
    end
  end

  // [RULE5] feed scrambled data
  // [RULE12] descrambler feeds received bit
  assign ser_fb = descramble ? ser_in : ser_out;
  assign par_fb = descramble ? in_data : tree_out;

  // ----------------------------------------------------------------
  // LFSR state
  // ----------------------------------------------------------------
  // Async reset only reaches the seed constant; srst is the block reset.
  // [RULE14] block reset seed
  // [RULE9] reinit seed
  // [RULE11] reinit over bypass
  // [RULE13] step-gated update
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= SEED;
    end else if (srst || reinit) begin
      state_r <= SEED;
    end else if (step && !bypass) begin
      if (serial_mode) begin
        // [RULE8] serial shift
        state_r <= {state_r[STATE_W-2:0], ser_fb};
      end else begin
        // [RULE2] word step
        // [RULE6] state transition
        state_r <= {state_r[UPPER_W-1:0], par_fb};
      end
    end
  end

  // ----------------------------------------------------------------
  // Output buffer
  // ----------------------------------------------------------------
  // Back-pressure from the serializer side stalls steps via in_ready.
  lfs_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .srst     (srst),
    .wr_valid (in_valid),
    .wr_data  (word_out),
    .wr_ready (in_ready),
    .rd_valid (out_valid),
    .rd_data  (out_data),
    .rd_ready (out_ready)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  logic quiet;
  assign quiet = !srst && !reinit;

  a_reinit_seed: assert property (reinit |=> state_r == SEED) // [RULE9]
    else $error("reinit did not load seed");
  a_srst_seed: assert property (srst |=> state_r == SEED) // [RULE14]
    else $error("block reset did not load seed");
  a_bypass_hold: assert property ( // [RULE10]
    quiet && bypass |=> $stable(state_r))
    else $error("state moved during bypass");
  a_idle_hold: assert property ( // [RULE13]
    quiet && !step |=> $stable(state_r))
    else $error("state moved without data");
  a_par_shift: assert property ( // [RULE6]
    quiet && step && !bypass && !serial_mode
    |=> state_r[STATE_W-1:WORD_W] == $past(state_r[UPPER_W-1:0]))
    else $error("word step upper shift wrong");
  a_par_feed: assert property ( // [RULE5]
    quiet && step && !bypass && !serial_mode
    |=> state_r[WORD_W-1:0] ==
        ($past(descramble) ? $past(in_data) : $past(word_out)))
    else $error("word step fed wrong data");
  a_tree_msb: assert property ( // [RULE4]
    step && !bypass && !serial_mode
    |-> word_out[WORD_W-1] == (state_r[57] ^ state_r[38] ^ in_data[31]))
    else $error("tree bit 31 wrong");
  a_ser_shift: assert property ( // [RULE8]
    quiet && step && !bypass && serial_mode
    |=> state_r[STATE_W-1:1] == $past(state_r[STATE_W-2:0])
        && state_r[0] == ($past(descramble) ? $past(ser_in)
                                            : $past(ser_out)))
    else $error("serial step wrong");
  a_bypass_data: assert property ( // [RULE11]
    step && bypass && !serial_mode |-> word_out == in_data)
    else $error("bypass altered data");

  // ----------------------------------------------------------------
  // Bit-level checks
  // ----------------------------------------------------------------
  // Spot bits of the tree, so a slipped part-select shows up at once
  a_ser_width: assert property ( // [RULE7]
    serial_mode |-> word_out[WORD_W-1:1] == '0)
    else $error("serial output wider than one bit");

  a_ser_taps: assert property ( // [RULE1]
    !bypass && serial_mode
    |-> word_out[0] == (state_r[TAP_HI-1] ^ state_r[TAP_LO-1] ^ in_data[0]))
    else $error("serial taps wrong");

  a_ser_bypass: assert property ( // [RULE10]
    bypass && serial_mode |-> word_out[0] == in_data[0])
    else $error("serial bypass altered bit");

  a_tree_lsb: assert property ( // [RULE4]
    !bypass && !serial_mode
    |-> word_out[0] == (state_r[26] ^ state_r[7] ^ in_data[0]))
    else $error("tree bit 0 wrong");

  a_tree_mid: assert property ( // [RULE3]
    !bypass && !serial_mode
    |-> word_out[12] == (state_r[38] ^ state_r[19] ^ in_data[12]))
    else $error("tree bit 12 wrong");

  a_tree_taps: assert property ( // [RULE1]
    !bypass && !serial_mode
    |-> word_out[WORD_W-1] == (state_r[TAP_HI-1] ^ state_r[TAP_LO-1]
                               ^ in_data[WORD_W-1]))
    else $error("word taps wrong");

  a_reinit_prio: assert property ( // [RULE11]
    reinit && bypass |=> state_r == SEED)
    else $error("bypass beat reinit");

  a_ser_desc_feed: assert property ( // [RULE12]
    quiet && step && !bypass && serial_mode && descramble
    |=> state_r[0] == $past(in_data[0]))
    else $error("serial descrambler fed wrong bit");

  a_par_desc_feed: assert property ( // [RULE5]
    quiet && step && !bypass && !serial_mode && descramble
    |=> state_r[WORD_W-1:0] == $past(in_data))
    else $error("word descrambler fed wrong data");

  a_par_low_step: assert property ( // [RULE6]
    quiet && step && !bypass && !serial_mode
    |=> state_r[WORD_W] == $past(state_r[0]))
    else $error("state bit 1 did not move to 33");

  // Block reset must flush the buffer, or stale words follow a reseed
  a_srst_empty: assert property ( // [RULE14]
    srst |=> !out_valid)
    else $error("block reset left output valid");
endmodule : lfs_scrambler
`default_nettype wire

// [src/lfs_pkg.sv]
// Shared constants for the x^58 + x^39 + 1 frame scrambler
package lfs_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int STATE_W = 58;
  localparam int WORD_W  = 32;
  localparam int UPPER_W = STATE_W - WORD_W;

  // ----------------------------------------------------------------
  // Polynomial taps (1-based state positions)
  // ----------------------------------------------------------------
  localparam int TAP_HI = 58;
  localparam int TAP_LO = 39;

  // ----------------------------------------------------------------
  // Seed loaded by reinitialize and by reset
  // ----------------------------------------------------------------
  localparam logic [UPPER_W-1:0] SEED_HI = 26'h0294387;
  localparam logic [WORD_W-1:0]  SEED_LO = 32'h98327338;
  localparam logic [STATE_W-1:0] SEED    = {SEED_HI, SEED_LO};

  // ----------------------------------------------------------------
  // Output buffering
  // ----------------------------------------------------------------
  localparam int FIFO_DEPTH = 16;
endpackage : lfs_pkg

// [src/lfs_fifo.sv]
// Synchronous FIFO with registered read data and registered full flag
`timescale 1ns/1ps
`default_nettype none
module lfs_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             srst,
  // Write side
  input  wire logic             wr_valid,
  input  wire logic [WIDTH-1:0] wr_data,
  output var  logic             wr_ready,
  // Read side
  output var  logic             rd_valid,
  output var  logic [WIDTH-1:0] rd_data,
  input  wire logic             rd_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr_r;
  logic [AW-1:0]    rptr_r;
  logic [CW-1:0]    cnt_r;
  logic [CW-1:0]    cnt_nxt;
  logic             push;
  logic             pop;

  assign push = wr_valid & wr_ready;
  // Output register refills whenever empty or being drained
  assign pop  = (cnt_r != '0) & (~rd_valid | rd_ready);

  always_comb begin
    cnt_nxt = cnt_r;
    if (push & ~pop) begin
      cnt_nxt = cnt_r + CW'(1);
    end else if (pop & ~push) begin
      cnt_nxt = cnt_r - CW'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wptr_r] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_r   <= '0;
      rptr_r   <= '0;
      cnt_r    <= '0;
      wr_ready <= 1'b0;
    end else if (srst) begin
      wptr_r   <= '0;
      rptr_r   <= '0;
      cnt_r    <= '0;
      wr_ready <= 1'b1;
    end else begin
      if (push) begin
        wptr_r <= (wptr_r == AW'(DEPTH - 1)) ? '0 : wptr_r + AW'(1);
      end
      if (pop) begin
        rptr_r <= (rptr_r == AW'(DEPTH - 1)) ? '0 : rptr_r + AW'(1);
      end
      cnt_r    <= cnt_nxt;
      wr_ready <= (cnt_nxt != FULL_CNT);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
      rd_data  <= '0;
    end else if (srst) begin
      rd_valid <= 1'b0;
      rd_data  <= '0;
    end else if (pop) begin
      rd_valid <= 1'b1;
      rd_data  <= mem[rptr_r];
    end else if (rd_ready) begin
      rd_valid <= 1'b0;
    end
  end
endmodule : lfs_fifo
`default_nettype wire

// [verification/lfs_sink.sv]
// Consumer model standing in for the serializer on the output side
`timescale 1ns/1ps
`default_nettype none
module lfs_sink
  import lfs_pkg::*;
(
  // Clock
  input  wire logic              ref_clk,
  // Stream from the scrambler
  input  wire logic              out_valid,
  input  wire logic [WORD_W-1:0] out_data,
  output var  logic              out_ready,
  // Bench control and capture
  input  wire logic              stall,
  output var  logic              seen,
  output var  logic [WORD_W-1:0] seen_data
);
  initial begin
    out_ready = 1'b0;
    seen      = 1'b0;
  end
  // Ready moves between edges only, so a stall never cuts a word in half
  always @(negedge ref_clk) out_ready <= !stall;
  always @(posedge ref_clk) begin
    seen      <= out_valid && out_ready;
    seen_data <= out_data;
  end
endmodule : lfs_sink
`default_nettype wire

// [verification/tb_top.sv]
// Self-checking bench for the frame scrambler
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import lfs_pkg::*;
  localparam int DEPTH = 4;
  logic               ref_clk, rst_n, srst, descramble, serial_mode;
  logic               reinit, bypass, in_valid, in_ready;
  logic               out_valid, out_ready, stall, seen;
  logic [WORD_W-1:0]  in_data, out_data, seen_data;
  logic [STATE_W-1:0] state_r, mst;
  logic [WORD_W-1:0]  expq[$];
  int                 error_cnt, tests_run, k;
  lfs_scrambler #(.DEPTH(DEPTH)) lfs_scrambler_i (.ref_clk(ref_clk),
    .rst_n(rst_n), .srst(srst), .descramble(descramble),
    .serial_mode(serial_mode), .reinit(reinit), .bypass(bypass),
    .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
    .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready),
    .state_r(state_r));
  lfs_sink lfs_sink_i (.ref_clk(ref_clk), .out_valid(out_valid),
    .out_data(out_data), .out_ready(out_ready), .stall(stall),
    .seen(seen), .seen_data(seen_data));
  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task check(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task report_and_stop;
    $display("mismatches %0d, comparisons %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  // One step; hold keeps valid up so the next call follows back to back
  task push(input logic [31:0] d, input logic b, r, h);
    logic [31:0] o;
    int          n;
    o = serial_mode ? {31'h0, d[0] ^ (!b & (mst[57] ^ mst[38]))}
                    : d ^ (b ? 32'h0 : mst[57:26] ^ mst[38:7]);
    expq.push_back(o);
    in_valid = 1'b1;
    in_data  = d;
    bypass   = b;
    reinit   = r;
    n = 0;
    while (in_ready !== 1'b1 && n < 50) begin
      @(negedge ref_clk);
      n++;
    end
    @(negedge ref_clk);
    // A held step leaves the controls to the next call, so none toggles twice
    if (!h) {in_valid, bypass, reinit} = 3'h0;
    if (r) mst = SEED;
    else if (!b && serial_mode)
      mst = {mst[56:0], descramble ? d[0] : o[0]};
    else if (!b) mst = {mst[25:0], descramble ? d : o};
    check(state_r, mst);
  endtask : push
  task drain;
    int n;
    stall = 1'b0;
    n = 0;
    while (expq.size() != 0 && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    check(expq.size(), 0);
  endtask : drain
  always @(negedge ref_clk)
    if (seen === 1'b1) begin
      if (expq.size() == 0) check(1, 0);
      else check(seen_data, expq.pop_front());
    end
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Run needs well under a thousand cycles
  initial begin
    #1000000;
    error_cnt++;
    report_and_stop();
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    {rst_n, srst, descramble, serial_mode, reinit, bypass} = 6'h0;
    {in_valid, stall, in_data, error_cnt, tests_run, mst} = '0;
    mst = SEED;
    repeat (12) @(negedge ref_clk);
    check(state_r, SEED);
    check(out_valid, 1'b0);
    rst_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    push(32'h0, 0, 0, 1);
    push(32'hffffffff, 0, 0, 1);
    push(32'h12345678, 0, 0, 1);
    push(32'h5a5a5a5a, 1, 0, 1);
    push(32'hc3c3c3c3, 1, 1, 1);
    push(32'h0f0f0f0f, 0, 0, 1);
    push(32'h87654321, 0, 1, 0);
    drain();
    descramble = 1'b1;
    push(32'hdeadbeef, 0, 0, 1);
    push(32'h00c0ffee, 0, 0, 0);
    drain();
    serial_mode = 1'b1;
    for (k = 0; k < 12; k++) begin
      descramble = k > 5;
      push(k * 32'h9e3779b9, k == 3, 0, k != 11);
    end
    drain();
    srst = 1'b1;
    @(negedge ref_clk);
    {srst, serial_mode, descramble} = 3'h0;
    mst = SEED;
    check(state_r, SEED);
    stall = 1'b1;
    for (k = 0; k < 20 && in_ready === 1'b1; k++)
      push(k, 0, 0, 1);
    repeat (3) @(negedge ref_clk);
    check(state_r, mst);
    check(k, DEPTH + 1);
    in_valid = 1'b0;
    drain();
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
